// >>> hw/irq_bank.sv
// Sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/1ps
`default_nettype none
module irq_bank (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Events and software access
    input wire logic [sps_pkg::IRQ_W-1:0] event_in,
    input wire logic [sps_pkg::IRQ_W-1:0] clear_ones,
    input wire logic mask_we,
    input wire logic [sps_pkg::IRQ_W-1:0] mask_wdata,
    // State out
    output logic [sps_pkg::IRQ_W-1:0] status_q,
    output logic [sps_pkg::IRQ_W-1:0] mask_q,
    output logic irq
);
    import sps_pkg::*;
    // ==========================================
    // Status bits, set wins over clear
    genvar i;
    for (i = 0; i < IRQ_W; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                status_q[i] <= 1'b0;
            end else if (event_in[i]) begin
                status_q[i] <= 1'b1;
            end else if (clear_ones[i]) begin
                status_q[i] <= 1'b0;
            end
        end
    end
    // Mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= IRQ_RESET;
        end else if (mask_we) begin
            mask_q <= mask_wdata;
        end
    end
    // Level interrupt
    assign irq = |(status_q & mask_q);
endmodule // irq_bank
`default_nettype wire

// >>> hw/serial_port_status_register.sv
// Status register bank of a combined SPI / I2C serial port
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Edge bit selects SMBus input thresholds in I2C mode
// - Stop flag sets on stop, clears on start or disable
// - Direction bit captured at address match
// - Master activity is master bit AND the OR of direction, enables
// - Start/stop flags clear on reset, disable
// - Address matches only equal 7-bit slave address
module serial_port_status_register (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bus engine events
    input wire logic start_seen,
    input wire logic stop_seen,
    input wire logic nack_seen,
    input wire logic addr_byte_done,
    input wire logic [7:0] addr_byte,
    input wire logic data_byte_done,
    input wire logic [7:0] rx_byte,
    input wire logic tx_shifting,
    input wire logic ten_bit_update,
    // Status to the bus engine
    output logic smbus_thresholds,
    output logic slew_or_sample,
    output logic master_active,
    output logic port_enable,
    output logic irq
);
    import sps_pkg::*;
    // ==========================================
    // Registers
    logic [7:0] status_q; // Status bits
    logic [7:0] control_q; // Control bits
    logic [7:0] slave_addr_q; // Slave address
    logic [7:0] buffer_q; // Received byte
    logic [IRQ_W-1:0] irq_stat; // Sticky events
    logic [IRQ_W-1:0] irq_mask; // Event mask
    logic addr_match; // Matching address byte
    logic wr_en; // Write access phase
    logic rd_en; // Read access phase
    logic rd_buffer; // Software reads buffer
    logic [7:0] wdata8; // Low byte of write
    // ==========================================
    // Bus decode, single-cycle answer
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign wdata8 = pwdata[7:0];
    assign rd_buffer = rd_en && (paddr == ADDR_BUFFER);
    // Unmapped address flags an error
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            case (paddr)
                ADDR_STATUS, ADDR_CONTROL, ADDR_ADDRESS,
                ADDR_BUFFER, ADDR_IRQ_STATUS, ADDR_IRQ_MASK: begin
                    pslverr = 1'b0;
                end
                default: begin
                    pslverr = 1'b1;
                end
            endcase
        end
    end
    // Read data registered in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_STATUS: prdata <= {24'h00_0000, status_q};
                ADDR_CONTROL: prdata <= {24'h00_0000, control_q};
                ADDR_ADDRESS: prdata <= {24'h00_0000, slave_addr_q};
                ADDR_BUFFER: prdata <= {24'h00_0000, buffer_q};
                ADDR_IRQ_STATUS: prdata <= {28'h000_0000, irq_stat};
                ADDR_IRQ_MASK: prdata <= {28'h000_0000, irq_mask};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
    // ==========================================
    // Control and address registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= CONTROL_RESET;
        end else if (wr_en && paddr == ADDR_CONTROL) begin
            control_q <= wdata8;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slave_addr_q <= ADDRESS_RESET;
        end else if (wr_en && paddr == ADDR_ADDRESS) begin
            slave_addr_q <= wdata8;
        end
    end
    assign port_enable = control_q[CTL_PORT_EN];
    // Compare the 7-bit address, direction bit excluded
    assign addr_match = addr_byte_done &&
        (addr_byte[7:1] == slave_addr_q[7:1]);
    // ==========================================
    // Software-written configuration bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q[STAT_SAMPLE] <= 1'b0;
            status_q[STAT_EDGE] <= 1'b0;
        end else if (wr_en && paddr == ADDR_STATUS) begin
            status_q[STAT_SAMPLE] <= wdata8[STAT_SAMPLE];
            status_q[STAT_EDGE] <= wdata8[STAT_EDGE];
        end
    end
    // Threshold select only in I2C mode
    assign smbus_thresholds = control_q[CTL_I2C_MODE] &&
        status_q[STAT_EDGE];
    assign slew_or_sample = status_q[STAT_SAMPLE];
    // ==========================================
    // Start and stop detection flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q[STAT_START] <= 1'b0;
            status_q[STAT_STOP] <= 1'b0;
        end else if (!port_enable) begin
            status_q[STAT_START] <= 1'b0;
            status_q[STAT_STOP] <= 1'b0;
        end else if (start_seen) begin
            status_q[STAT_START] <= 1'b1;
            status_q[STAT_STOP] <= 1'b0;
        end else if (stop_seen) begin
            status_q[STAT_STOP] <= 1'b1;
            status_q[STAT_START] <= 1'b0;
        end
    end
    // ==========================================
    // Direction and data/address bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q[STAT_DIR] <= 1'b0;
        end else if (!port_enable) begin
            status_q[STAT_DIR] <= 1'b0;
        end else if (addr_match) begin
            status_q[STAT_DIR] <= addr_byte[0];
        end else if (start_seen || stop_seen || nack_seen) begin
            status_q[STAT_DIR] <= 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q[STAT_DATA_ADDR] <= 1'b0;
        end else if (!port_enable) begin
            status_q[STAT_DATA_ADDR] <= 1'b0;
        end else if (data_byte_done) begin
            status_q[STAT_DATA_ADDR] <= 1'b1;
        end else if (addr_byte_done) begin
            status_q[STAT_DATA_ADDR] <= 1'b0;
        end
    end
    // Address update request, cleared by address write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q[STAT_UPDATE] <= 1'b0;
        end else if (!port_enable) begin
            status_q[STAT_UPDATE] <= 1'b0;
        end else if (ten_bit_update) begin
            status_q[STAT_UPDATE] <= 1'b1;
        end else if (wr_en && paddr == ADDR_ADDRESS) begin
            status_q[STAT_UPDATE] <= 1'b0;
        end
    end
    // ==========================================
    // Buffer and full flag, set wins over read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buffer_q <= 8'h00;
        end else if (data_byte_done) begin
            buffer_q <= rx_byte;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q[STAT_FULL] <= 1'b0;
        end else if (!port_enable) begin
            status_q[STAT_FULL] <= 1'b0;
        end else if (data_byte_done || tx_shifting) begin
            status_q[STAT_FULL] <= 1'b1;
        end else if (rd_buffer) begin
            status_q[STAT_FULL] <= 1'b0;
        end
    end
    // ==========================================
    // Master activity indicator
    assign master_active = control_q[CTL_MASTER] &&
        (status_q[STAT_DIR] || control_q[CTL_START_GEN] ||
         control_q[CTL_RSTART_GEN] || control_q[CTL_STOP_GEN] ||
         control_q[CTL_RECV_EN] || control_q[CTL_ACK_EN]);
    // ==========================================
    // Interrupts
    irq_bank u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .event_in({addr_match, data_byte_done,
                   stop_seen && port_enable, start_seen && port_enable}),
        .clear_ones((wr_en && paddr == ADDR_IRQ_STATUS) ?
                    pwdata[IRQ_W-1:0] : IRQ_RESET),
        .mask_we(wr_en && paddr == ADDR_IRQ_MASK),
        .mask_wdata(pwdata[IRQ_W-1:0]),
        .status_q(irq_stat),
        .mask_q(irq_mask),
        .irq(irq)
    );
    // ==========================================
    // Checks
    sequence s_stop_seen;
        port_enable && stop_seen && !start_seen;
    endsequence
    a_stop_flag_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_stop_seen |=> status_q[STAT_STOP])
        else $error("stop flag not set");
    a_flags_disable: assert property (
        @(posedge pclk) disable iff (!presetn)
        !port_enable |=> !status_q[STAT_STOP] && !status_q[STAT_START])
        else $error("flags not cleared on disable");
    a_dir_capture: assert property (
        @(posedge pclk) disable iff (!presetn)
        port_enable && addr_match
        |=> status_q[STAT_DIR] == $past(addr_byte[0]))
        else $error("direction not captured");
    a_dir_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        !addr_match && nack_seen |=> !status_q[STAT_DIR])
        else $error("direction not cleared");
    a_match_eq: assert property (
        @(posedge pclk) disable iff (!presetn)
        addr_byte_done && addr_byte[7:1] != slave_addr_q[7:1] && port_enable
        && !start_seen && !stop_seen && !nack_seen
        |=> $stable(status_q[STAT_DIR]))
        else $error("mismatch changed direction");
    a_full_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        port_enable && data_byte_done |=> status_q[STAT_FULL])
        else $error("full not set");
    a_full_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        port_enable && rd_buffer && !data_byte_done && !tx_shifting
        |=> !status_q[STAT_FULL])
        else $error("full not cleared by read");
    // Threshold select follows a status write while in I2C mode
    a_thresh_sel: assert property (
        @(posedge pclk) disable iff (!presetn)
        control_q[CTL_I2C_MODE] && wr_en && paddr == ADDR_STATUS
        |=> smbus_thresholds == $past(wdata8[STAT_EDGE]))
        else $error("threshold select wrong");
    a_master_or: assert property (
        @(posedge pclk) disable iff (!presetn)
        control_q[CTL_MASTER] && status_q[STAT_DIR] |-> master_active)
        else $error("master activity missing");
endmodule // serial_port_status_register
`default_nettype wire

// >>> hw/sps_pkg.sv
// Package: register map and field layout of the serial port status block
package sps_pkg;
    // ==========================================
    // Register byte addresses
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_ADDRESS = 12'h008;
    localparam logic [11:0] ADDR_BUFFER = 12'h00c;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h010;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;
    // ==========================================
    // Status register fields
    localparam int STAT_SAMPLE = 7;
    localparam int STAT_EDGE = 6;
    localparam int STAT_DATA_ADDR = 5;
    localparam int STAT_STOP = 4;
    localparam int STAT_START = 3;
    localparam int STAT_DIR = 2;
    localparam int STAT_UPDATE = 1;
    localparam int STAT_FULL = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Writable bits of the status register
    localparam logic [7:0] STATUS_WR_MASK = 8'hc0;
    // ==========================================
    // Control register fields
    localparam int CTL_PORT_EN = 0;
    localparam int CTL_I2C_MODE = 1;
    localparam int CTL_MASTER = 2;
    localparam int CTL_START_GEN = 3;
    localparam int CTL_RSTART_GEN = 4;
    localparam int CTL_STOP_GEN = 5;
    localparam int CTL_RECV_EN = 6;
    localparam int CTL_ACK_EN = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] ADDRESS_RESET = 8'h00;
    // ==========================================
    // Interrupt bits
    localparam int IRQ_START = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_FULL = 2;
    localparam int IRQ_MATCH = 3;
    localparam int IRQ_W = 4;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
endpackage

// >>> tb/bus_engine_model.sv
// Behavioural serial bus engine driving event pulses into the status block
`timescale 1ns/1ps
`default_nettype none
module bus_engine_model (
    // Clock
    input wire logic pclk,
    // Event pulses
    output wire logic start_seen,
    output wire logic stop_seen,
    output wire logic nack_seen,
    output wire logic addr_byte_done,
    output wire logic data_byte_done,
    output wire logic ten_bit_update,
    // Bytes and transmit level
    output logic [7:0] addr_byte,
    output logic [7:0] rx_byte,
    output logic tx_shifting
);
    // One-hot pulse vector, bit k for event kind k
    logic [5:0] pulse_q = 6'h00;
    assign {ten_bit_update, data_byte_done, addr_byte_done, nack_seen,
            stop_seen, start_seen} = pulse_q;
    // Idle lines at time zero
    initial begin
        addr_byte = 8'h00;
        rx_byte = 8'h00;
        tx_shifting = 1'b0;
    end
    // Kinds: 0 start 1 stop 2 nack 3 addr 4 data 5 update 6 tx level
    task automatic ev(input int k, input logic [7:0] b);
        @(posedge pclk);
        pulse_q <= 6'(1 << k);
        addr_byte <= b;
        rx_byte <= b;
        if (k == 6) tx_shifting <= b[0];
        @(posedge pclk);
        pulse_q <= 6'h00;
        // Released bytes flip so a stale value never looks valid
        addr_byte <= ~b;
        rx_byte <= ~b;
    endtask
endmodule // bus_engine_model
`default_nettype wire

// >>> tb/tb.sv
// Self-checking testbench of the serial port status register block
`timescale 1ns/1ps
`default_nettype none
// Compare and count; a mismatch prints at once
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    mismatches++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
    import sps_pkg::*;
    // ==============================
    // Bench signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rdat;  // Last read data
    logic rerr;  // Last error response
    int mismatches = 0;
    int check_count = 0;
    // Design outputs and engine events
    wire logic [31:0] prdata;
    wire logic pready, pslverr, smbus_thresholds, slew_or_sample;
    wire logic master_active, port_enable, irq, tx_shifting;
    wire logic start_seen, stop_seen, nack_seen, addr_byte_done;
    wire logic data_byte_done, ten_bit_update;
    wire logic [7:0] addr_byte, rx_byte;
    // ==============================
    // Design and bus engine model
    serial_port_status_register u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .start_seen, .stop_seen, .nack_seen,
        .addr_byte_done, .addr_byte, .data_byte_done, .rx_byte,
        .tx_shifting, .ten_bit_update, .smbus_thresholds, .slew_or_sample,
        .master_active, .port_enable, .irq
    );
    bus_engine_model u_eng (
        .pclk, .start_seen, .stop_seen, .nack_seen, .addr_byte_done,
        .data_byte_done, .ten_bit_update, .addr_byte, .rx_byte, .tx_shifting
    );
    // 50 ns clock
    initial begin
        forever #25 pclk = ~pclk;
    end
    // ==============================
    // APB master: setup, access until pready, then release
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // Read and compare data and error response
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic xe);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rdat, x)
        `CHK(rerr, xe)
    endtask
    // ==============================
    // Scenarios
    task automatic test_flags();
        rd(ADDR_STATUS, 32'h0000_0000, 1'b0);
        `CHK(port_enable, 1'b0)
        `CHK(pready, 1'b1)
        rd(12'h020, 32'h0000_0000, 1'b1);
        wr(ADDR_CONTROL, 32'h0000_0003);
        @(negedge pclk);
        `CHK(port_enable, 1'b1)
        u_eng.ev(0, 8'h00);
        rd(ADDR_STATUS, 32'h0000_0008, 1'b0);
        u_eng.ev(1, 8'h00);
        rd(ADDR_STATUS, 32'h0000_0010, 1'b0);
        wr(ADDR_CONTROL, 32'h0000_0002);
        rd(ADDR_STATUS, 32'h0000_0000, 1'b0);
        wr(ADDR_CONTROL, 32'h0000_0003);
        u_eng.ev(0, 8'h00);
        wr(ADDR_CONTROL, 32'h0000_0002);
        rd(ADDR_STATUS, 32'h0000_0000, 1'b0);
        $display("flags test done");
    endtask
    task automatic test_address();
        wr(ADDR_CONTROL, 32'h0000_0003);
        wr(ADDR_ADDRESS, 32'h0000_00a4);
        u_eng.ev(3, 8'ha5);
        rd(ADDR_STATUS, 32'h0000_0004, 1'b0);
        u_eng.ev(3, 8'h56);
        rd(ADDR_STATUS, 32'h0000_0004, 1'b0);
        u_eng.ev(2, 8'h00);
        rd(ADDR_STATUS, 32'h0000_0000, 1'b0);
        u_eng.ev(3, 8'ha5);
        u_eng.ev(1, 8'h00);
        rd(ADDR_STATUS, 32'h0000_0010, 1'b0);
        // Address update request set by engine, cleared by address write
        u_eng.ev(5, 8'h00);
        rd(ADDR_STATUS, 32'h0000_0012, 1'b0);
        wr(ADDR_ADDRESS, 32'h0000_00a4);
        rd(ADDR_STATUS, 32'h0000_0010, 1'b0);
        $display("address test done");
    endtask
    task automatic test_master();
        wr(ADDR_CONTROL, 32'h0000_0007);
        u_eng.ev(3, 8'ha5);
        @(negedge pclk);
        `CHK(master_active, 1'b1)
        u_eng.ev(2, 8'h00);
        @(negedge pclk);
        `CHK(master_active, 1'b0)
        // Stop flag from the address test still set, direction cleared by nack
        rd(ADDR_STATUS, 32'h0000_0010, 1'b0);
        for (int i = 3; i < 8; i++) begin
            wr(ADDR_CONTROL, 32'h0000_0007 | (32'h0000_0001 << i));
            @(negedge pclk);
            `CHK(master_active, 1'b1)
        end
        wr(ADDR_CONTROL, 32'h0000_00fb);
        @(negedge pclk);
        `CHK(master_active, 1'b0)
        $display("master test done");
    endtask
    task automatic test_full();
        wr(ADDR_CONTROL, 32'h0000_0002);
        wr(ADDR_CONTROL, 32'h0000_0003);
        u_eng.ev(4, 8'h3c);
        rd(ADDR_STATUS, 32'h0000_0021, 1'b0);
        rd(ADDR_BUFFER, 32'h0000_003c, 1'b0);
        rd(ADDR_STATUS, 32'h0000_0020, 1'b0);
        u_eng.ev(6, 8'h01);
        rd(ADDR_BUFFER, 32'h0000_003c, 1'b0);
        rd(ADDR_STATUS, 32'h0000_0021, 1'b0);
        u_eng.ev(6, 8'h00);
        rd(ADDR_BUFFER, 32'h0000_003c, 1'b0);
        rd(ADDR_STATUS, 32'h0000_0020, 1'b0);
        $display("full test done");
    endtask
    task automatic test_edge_irq();
        wr(ADDR_CONTROL, 32'h0000_0002);
        wr(ADDR_STATUS, 32'h0000_00ff);
        rd(ADDR_STATUS, 32'h0000_00c0, 1'b0);
        `CHK(smbus_thresholds, 1'b1)
        wr(ADDR_CONTROL, 32'h0000_0001);
        @(negedge pclk);
        `CHK(smbus_thresholds, 1'b0)
        `CHK(slew_or_sample, 1'b1)
        wr(ADDR_IRQ_STATUS, 32'h0000_000f);
        wr(ADDR_IRQ_MASK, 32'h0000_0001);
        u_eng.ev(0, 8'h00);
        @(negedge pclk);
        `CHK(irq, 1'b1)
        wr(ADDR_IRQ_MASK, 32'h0000_0002);
        wr(ADDR_IRQ_STATUS, 32'h0000_0001);
        @(negedge pclk);
        `CHK(irq, 1'b0)
        u_eng.ev(1, 8'h00);
        rd(ADDR_IRQ_STATUS, 32'h0000_0002, 1'b0);
        `CHK(irq, 1'b1)
        $display("edge and irq test done");
    endtask
    // ==============================
    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence after ten reset cycles
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        test_flags();
        test_address();
        test_master();
        test_full();
        test_edge_irq();
        report_and_stop();
    end
    // Watchdog far beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
